/* File: srcc_ctrl.sv */
// Sensor reset and offset correction control register with sequencing
`timescale 1ns/1ps
//
// Function
// [R01] Auto bit7, raw bit5, trigger bit4 at 0x11
// [R02] All three control bits clear after reset
// [R03] Auto enable resets sensor before each acquisition
// [R04] Host should set auto enable explicitly
// [R05] Raw select is write-only, reads zero
// [R06] Normal subtracts user offsets; raw skips them
// [R07] Calibrated data always passed, raw or not
// [R08] Writing trigger one starts sensor reset cycle
// [R09] Trigger reads one while reset cycle runs
// [R10] Trigger clears itself when cycle completes
// [R11] Host polls trigger to zero before trusting data
module srcc_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port from the serial slave
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // Measurement front end
  input wire logic acq_req,
  output logic acq_start,
  input wire logic meas_valid,
  input wire logic [15:0] meas_x,
  input wire logic [15:0] meas_y,
  input wire logic [15:0] meas_z,
  // User offsets
  input wire logic [15:0] off_x,
  input wire logic [15:0] off_y,
  input wire logic [15:0] off_z,
  // Sensor reset drive and corrected data
  output logic coil_drive,
  output logic [15:0] data_x,
  output logic [15:0] data_y,
  output logic [15:0] data_z,
  output logic data_valid
);
  srcc_seq_if sq ();
  srcc_pkg::srcc_state_t state_reg;
  srcc_pkg::srcc_state_t state_next;
  logic auto_reg;
  logic raw_reg;
  logic mrst_reg;
  logic ctrl_wr;
  logic mrst_set;
  logic acq_start_reg;
  logic [15:0] data_x_reg;
  logic [15:0] data_y_reg;
  logic [15:0] data_z_reg;
  logic data_valid_reg;
  logic [7:0] rd_data_reg;

  srcc_reset_seq #(.CYCLES(srcc_pkg::SRCC_RST_CYCLES)) u_seq (
    .clk(clk),
    .rst(rst),
    .sq(sq)
  );

  assign ctrl_wr = reg_wr_en && reg_addr == srcc_pkg::SRCC_CTRL_ADDR;
  assign mrst_set = ctrl_wr && reg_wr_data[srcc_pkg::SRCC_MRST_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_reg <= srcc_pkg::SRCC_AUTO_RESET; // R02
      raw_reg <= srcc_pkg::SRCC_RAW_RESET; // R02
    end else if (ctrl_wr) begin
      auto_reg <= reg_wr_data[srcc_pkg::SRCC_AUTO_BIT]; // R01
      raw_reg <= reg_wr_data[srcc_pkg::SRCC_RAW_BIT]; // R01
    end
  end

  // A new request in the completing cycle wins and runs one more cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mrst_reg <= srcc_pkg::SRCC_MRST_RESET; // R02
    end else if (mrst_set) begin
      mrst_reg <= 1'b1; // R08
    end else if (sq.done && state_reg == srcc_pkg::SRCC_ST_RST_MAN) begin
      mrst_reg <= 1'b0; // R10
    end
  end

  // Acquisition requests are taken only in idle; a manual reset goes first
  always_comb begin
    state_next = state_reg;
    sq.start = 1'b0;
    case (state_reg)
      srcc_pkg::SRCC_ST_IDLE: begin
        if (mrst_reg) begin
          state_next = srcc_pkg::SRCC_ST_RST_MAN;
          sq.start = 1'b1; // R08
        end else if (acq_req && auto_reg) begin
          state_next = srcc_pkg::SRCC_ST_RST_AUTO;
          sq.start = 1'b1; // R03
        end else if (acq_req) begin
          state_next = srcc_pkg::SRCC_ST_ACQ; // R03
        end
      end
      srcc_pkg::SRCC_ST_RST_MAN: begin
        if (sq.done) begin
          state_next = srcc_pkg::SRCC_ST_IDLE;
        end
      end
      srcc_pkg::SRCC_ST_RST_AUTO: begin
        if (sq.done) begin
          state_next = srcc_pkg::SRCC_ST_ACQ;
        end
      end
      srcc_pkg::SRCC_ST_ACQ: begin
        if (meas_valid) begin
          state_next = srcc_pkg::SRCC_ST_IDLE;
        end
      end
      default: begin
        state_next = srcc_pkg::SRCC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= srcc_pkg::SRCC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acq_start_reg <= 1'b0;
    end else begin
      acq_start_reg <= state_next == srcc_pkg::SRCC_ST_ACQ &&
                       state_reg != srcc_pkg::SRCC_ST_ACQ;
    end
  end

  // Inputs already carry factory calibration; only user offsets are optional
  always_ff @(posedge clk) begin
    if (rst) begin
      data_x_reg <= '0;
      data_y_reg <= '0;
      data_z_reg <= '0;
      data_valid_reg <= 1'b0;
    end else begin
      data_valid_reg <= 1'b0;
      if (state_reg == srcc_pkg::SRCC_ST_ACQ && meas_valid) begin
        data_valid_reg <= 1'b1;
        if (raw_reg) begin
          data_x_reg <= meas_x; // R06 R07
          data_y_reg <= meas_y;
          data_z_reg <= meas_z;
        end else begin
          data_x_reg <= meas_x - off_x; // R06 R07
          data_y_reg <= meas_y - off_y;
          data_z_reg <= meas_z - off_z;
        end
      end
    end
  end

  // Raw select reads back as zero; trigger bit shows pending or running cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else if (reg_rd_en) begin
      rd_data_reg <= '0;
      if (reg_addr == srcc_pkg::SRCC_CTRL_ADDR) begin
        rd_data_reg[srcc_pkg::SRCC_AUTO_BIT] <= auto_reg; // R01
        rd_data_reg[srcc_pkg::SRCC_MRST_BIT] <= mrst_reg || sq.busy; // R05 R09
      end
    end
  end

  assign reg_rd_data = rd_data_reg;
  assign acq_start = acq_start_reg;
  assign coil_drive = sq.coil_drive;
  assign data_x = data_x_reg;
  assign data_y = data_y_reg;
  assign data_z = data_z_reg;
  assign data_valid = data_valid_reg;

  property p_map;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> auto_reg == $past(reg_wr_data[7]) && raw_reg == $past(reg_wr_data[5]);
  endproperty
  a_map: assert property (p_map) else $error("control bits misplaced"); // R01

  property p_reset_zero;
    @(posedge clk) rst |=> !auto_reg && !raw_reg && !mrst_reg;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control bits not cleared"); // R02

  property p_auto_cycle;
    @(posedge clk) disable iff (rst)
      (state_reg == srcc_pkg::SRCC_ST_IDLE && !mrst_reg && acq_req && auto_reg)
      |=> sq.busy ##[10:12] acq_start;
  endproperty
  a_auto_cycle: assert property (p_auto_cycle) else $error("no reset before acquisition"); // R03

  property p_no_auto;
    @(posedge clk) disable iff (rst)
      (state_reg == srcc_pkg::SRCC_ST_IDLE && !mrst_reg && acq_req && !auto_reg)
      |=> acq_start && !sq.busy;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("unexpected automatic reset"); // R03

  property p_raw_hidden;
    @(posedge clk) disable iff (rst) !reg_rd_data[5];
  endproperty
  a_raw_hidden: assert property (p_raw_hidden) else $error("raw select read back"); // R05

  property p_offset;
    @(posedge clk) disable iff (rst)
      (state_reg == srcc_pkg::SRCC_ST_ACQ && meas_valid && !raw_reg)
      |=> data_valid && data_x == 16'($past(meas_x) - $past(off_x));
  endproperty
  a_offset: assert property (p_offset) else $error("offset not applied"); // R06

  property p_raw_pass;
    @(posedge clk) disable iff (rst)
      (state_reg == srcc_pkg::SRCC_ST_ACQ && meas_valid && raw_reg)
      |=> data_valid && data_z == $past(meas_z);
  endproperty
  a_raw_pass: assert property (p_raw_pass) else $error("raw data altered"); // R07

  property p_manual_start;
    @(posedge clk) disable iff (rst)
      (mrst_set && state_reg == srcc_pkg::SRCC_ST_IDLE) |=> mrst_reg ##1 sq.busy;
  endproperty
  a_manual_start: assert property (p_manual_start) else $error("manual reset not started"); // R08

  property p_busy_read;
    @(posedge clk) disable iff (rst)
      (reg_rd_en && reg_addr == srcc_pkg::SRCC_CTRL_ADDR && sq.busy) |=> reg_rd_data[4];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy not shown"); // R09

  property p_self_clear;
    @(posedge clk) disable iff (rst)
      (sq.done && state_reg == srcc_pkg::SRCC_ST_RST_MAN && !mrst_set) |=> !mrst_reg;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("trigger not cleared"); // R10
endmodule // srcc_ctrl

/* File: srcc_pkg.sv */
// Constants shared by the sensor reset and correction control block
package srcc_pkg;
  localparam logic [7:0] SRCC_CTRL_ADDR = 8'h11;
  localparam logic [7:0] SRCC_DATA_FIRST_ADDR = 8'h01;
  localparam logic [7:0] SRCC_DATA_LAST_ADDR = 8'h06;
  localparam int SRCC_AUTO_BIT = 7;
  localparam int SRCC_RAW_BIT = 5;
  localparam int SRCC_MRST_BIT = 4;
  localparam logic SRCC_AUTO_RESET = 1'b0;
  localparam logic SRCC_RAW_RESET = 1'b0;
  localparam logic SRCC_MRST_RESET = 1'b0;
  localparam int SRCC_DATA_W = 16;
  localparam int SRCC_CLK_PERIOD_NS = 100;
  localparam int SRCC_RST_PULSE_NS = 1000;
  localparam int SRCC_RST_CYCLES =
    (SRCC_RST_PULSE_NS + SRCC_CLK_PERIOD_NS - 1) / SRCC_CLK_PERIOD_NS;
  localparam int SRCC_CNT_W = 8;
  typedef enum logic [1:0] {
    SRCC_ST_IDLE = 2'b00,
    SRCC_ST_RST_MAN = 2'b01,
    SRCC_ST_RST_AUTO = 2'b11,
    SRCC_ST_ACQ = 2'b10
  } srcc_state_t;
endpackage

/* File: srcc_seq_if.sv */
// Handshake between the control logic and the reset pulse sequencer
`timescale 1ns/1ps
interface srcc_seq_if;
  logic start;
  logic busy;
  logic done;
  logic coil_drive;
  modport ctrl (output start, input busy, input done, input coil_drive);
  modport seq (input start, output busy, output done, output coil_drive);
endinterface

/* File: srcc_reset_seq.sv */
// Timed magnetic sensor reset pulse sequencer
`timescale 1ns/1ps
module srcc_reset_seq #(
  parameter int CYCLES = srcc_pkg::SRCC_RST_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  srcc_seq_if.seq sq
);
  logic [srcc_pkg::SRCC_CNT_W-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;

  localparam logic [srcc_pkg::SRCC_CNT_W-1:0] LAST = srcc_pkg::SRCC_CNT_W'(CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (!busy_reg && sq.start) begin
      busy_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (busy_reg && cnt_reg == LAST) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && cnt_reg == LAST;
    end
  end

  assign sq.busy = busy_reg;
  assign sq.done = done_reg;
  assign sq.coil_drive = busy_reg;

  // Helper run length, so the pulse check needs no long repetition
  logic [srcc_pkg::SRCC_CNT_W-1:0] len_reg;

  always_ff @(posedge clk) begin
    if (rst || !busy_reg) begin
      len_reg <= '0;
    end else begin
      len_reg <= len_reg + 1'b1;
    end
  end

  property p_pulse_len;
    @(posedge clk) disable iff (rst) $fell(busy_reg) |-> $past(len_reg) == LAST;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong"); // R08

  property p_pulse_max;
    @(posedge clk) disable iff (rst) busy_reg |-> len_reg <= LAST;
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("reset pulse too long"); // R08
endmodule // srcc_reset_seq

/* File: srcc_front_model.sv */
// Behavioural measurement front end answering acquisition starts
`timescale 1ns/1ps
module srcc_front_model #(
  parameter int DLY = 3
) (
  // Clock
  input wire logic clk,
  // Acquisition handshake
  input wire logic acq_start,
  output logic meas_valid,
  // Sample to deliver and the data lines
  input wire logic [47:0] sample,
  output logic [47:0] meas
);
  int cnt = 0;
  initial meas_valid = 1'b0;
  initial meas = 48'h0;
  // Outside a valid pulse the lines toggle so stale data is never mistaken for fresh
  always @(posedge clk) begin
    meas_valid <= 1'b0;
    meas <= ~meas;
    if (acq_start) begin
      cnt <= DLY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      meas_valid <= 1'b1;
      meas <= sample;
    end
  end
endmodule // srcc_front_model

/* File: srcc_ctrl_bench.sv */
// Self-checking bench for the sensor reset and correction control block
`timescale 1ns/1ps
module srcc_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, rv;
  logic wr = 1'b0, rd = 1'b0, aq = 1'b0, ast, mv, coil, dv;
  logic [47:0] smp = 48'h0, meas, off = 48'h0, dat;
  logic [15:0] seed = 16'h0014;
  int num_errors = 0, cmp_count = 0, coil_n = 0, n;
  logic [7:0] cfgs [4] = '{8'h00, 8'h20, 8'h80, 8'hA0};

  srcc_ctrl i_srcc_ctrl (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr_en(wr),
    .reg_wr_data(wdat), .reg_rd_en(rd), .reg_rd_data(rdat), .acq_req(aq),
    .acq_start(ast), .meas_valid(mv), .meas_x(meas[47:32]), .meas_y(meas[31:16]),
    .meas_z(meas[15:0]), .off_x(off[47:32]), .off_y(off[31:16]), .off_z(off[15:0]),
    .coil_drive(coil), .data_x(dat[47:32]), .data_y(dat[31:16]), .data_z(dat[15:0]),
    .data_valid(dv));
  srcc_front_model i_srcc_front_model (.clk(clk), .acq_start(ast), .meas_valid(mv),
    .sample(smp), .meas(meas));

  initial forever #50 clk = ~clk;
  always @(posedge clk) if (coil === 1'b1) coil_n++;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {addr, wdat, wr} = {a, d, 1'b1};
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {addr, rd} = {a, 1'b1};
    @(negedge clk) rd = 1'b0;
    d = rdat;
  endtask
  // One acquisition checked against the model of the current setting
  task automatic acq(input logic [7:0] c);
    logic [47:0] e;
    seed = lfsr(seed);
    smp = {seed, ~seed, seed ^ 16'h5A3C};
    seed = lfsr(seed);
    off = {16'h0, seed, 16'hFFFF};
    e = c[5] ? smp : {smp[47:32] - off[47:32], smp[31:16] - off[31:16], smp[15:0] - off[15:0]};
    coil_n = 0;
    @(negedge clk) aq = 1'b1;
    n = 0;
    repeat (40) begin
      @(negedge clk) aq = 1'b0;
      n++;
      if (ast === 1'b1) break;
    end
    chk("start latency", n, c[7] ? 12 : 1);
    repeat (40) begin
      @(negedge clk);
      if (dv === 1'b1) break;
    end
    chk("data", dat, e);
    chk("auto pulses", coil_n, c[7] ? srcc_pkg::SRCC_RST_CYCLES : 0);
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #500000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rreg(srcc_pkg::SRCC_CTRL_ADDR, rv);
    chk("reset value", rv, 8'h00);
    foreach (cfgs[i]) begin
      wreg(srcc_pkg::SRCC_CTRL_ADDR, cfgs[i]);
      wreg(8'h10, 8'hFF);
      rreg(srcc_pkg::SRCC_CTRL_ADDR, rv);
      chk("readback", rv, cfgs[i] & 8'h80);
      rreg(8'h12, rv);
      chk("unmapped", rv, 8'h00);
      acq(cfgs[i]);
      acq(cfgs[i]);
      coil_n = 0;
      wreg(srcc_pkg::SRCC_CTRL_ADDR, cfgs[i] | 8'h10);
      rreg(srcc_pkg::SRCC_CTRL_ADDR, rv);
      chk("busy", rv, (cfgs[i] & 8'h80) | 8'h10);
      n = 0;
      // Poll until the cycle ends before trusting data
      repeat (30) begin
        rreg(srcc_pkg::SRCC_CTRL_ADDR, rv);
        n++;
        if (rv[4] === 1'b0) break;
      end
      chk("self clear", rv, cfgs[i] & 8'h80);
      chk("manual pulses", coil_n, srcc_pkg::SRCC_RST_CYCLES);
      acq(cfgs[i]);
    end
    tally_and_finish();
  end
endmodule // srcc_ctrl_bench
